// >>> dmcp_checker_assertions.sv
`timescale 1ns/1ps
module dmcp_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  input wire logic sel,
  input wire logic sdo_oe
);
  typedef struct packed {
    logic seen_fall;
    logic sel_prev;
  } dmcp_chk_t;
  dmcp_chk_t st_q;
  dmcp_chk_t st_d;
  // Remember whether the select line has ever fallen since reset
  always_comb begin
    st_d = st_q;
    st_d.seen_fall = st_q.seen_fall | (st_q.sel_prev & ~sel);
    st_d.sel_prev = sel;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= 2'b01;
    end else begin
      st_q <= st_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_sdo_quiet_i2c: assert property (!st_q.seen_fall |-> !sdo_oe)
    else $error("serial out driven in two-wire mode");
  a_sda_quiet_spi: assert property (st_q.seen_fall |-> !sda_dev_oe)
    else $error("data line pulled in four-wire mode");
  a_sdo_off_deselect: assert property (sel [*4] |-> !sdo_oe)
    else $error("serial out driven while deselected");
  a_sdo_oe_selected: assert property ($rose(sdo_oe) |-> !sel)
    else $error("serial out enabled without select");
  a_sda_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("data line changed while clock high");
  a_ack_holds: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*4])
    else $error("pull on data line too short");
  a_start_released: assert property (scl && $past(scl) && $fell(sda) |-> !sda_dev_oe)
    else $error("device pulled data line at start");
  a_reset_idle: assert property ($fell(rst_i) |-> !sda_dev_oe && !sdo_oe)
    else $error("port driven after reset");
  // Main traffic kinds
  c_i2c_pull: cover property ($rose(sda_dev_oe));
  c_spi_out: cover property ($rose(sdo_oe));
  c_sel_fall: cover property ($fell(sel) && !st_q.seen_fall);
endmodule : dmcp_checker

// >>> dmcp_device.sv
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dmcp_regs.svh"
module dmcp_device
  import dmcp_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = 8'hf5 // Arbitrary identification value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  dmcp_if.dev port,
  input wire logic addr1_strap_pin_i,
  output logic spi_mode_o,
  output logic [7:0] pointer_o,
  output logic wr_stb_o,
  output logic [3:0] wr_index_o,
  output logic [7:0] wr_data_o
);
  typedef struct packed {
    dmcp_dstate_t st;
    logic spi;
    logic [7:0] ptr;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic sda_oe;
    logic sdo;
    logic scl_p;
    logic sda_p;
    logic sel_p;
    logic strap;
    logic [15:0][7:0] regs;
    logic wr_stb;
    logic [3:0] wr_idx;
    logic [7:0] wr_dat;
  } dmcp_dev_t;

  dmcp_dev_t s_q;
  dmcp_dev_t s_d;
  logic [4:0] sy;
  logic strap_s;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic sdi_s;

  // Link pins are foreign to clk_i; resynchronise
  dmcp_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({port.scl, port.sda, port.sel, port.sdi, addr1_strap_pin_i}),
    .q_o(sy)
  );
  assign {scl_s, sda_s, sel_s, sdi_s, strap_s} = sy;

  function automatic logic [3:0] next_idx(input logic [7:0] p);
    next_idx = p[`DMCP_PTR_AUTO_INCREMENT_ENABLE_BIT] ? p[3:0] + 4'h1 : p[3:0];
  endfunction : next_idx

  function automatic logic [7:0] rd_reg(input logic [15:0][7:0] r, input logic [3:0] i);
    rd_reg = (i == `DMCP_ID_INDEX) ? ID_VALUE : r[i];
  endfunction : rd_reg

  logic rise;
  logic fall;
  logic i2c_start;
  logic i2c_stop;
  logic sel_fall;
  logic sel_rise;
  logic [7:0] byte_in;
  assign rise = scl_s & ~s_q.scl_p;
  assign fall = ~scl_s & s_q.scl_p;
  assign i2c_start = ~s_q.spi & scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
  assign i2c_stop = ~s_q.spi & scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
  assign sel_fall = s_q.sel_p & ~sel_s;
  assign sel_rise = ~s_q.sel_p & sel_s;
  assign byte_in = {s_q.sh[6:0], s_q.spi ? sdi_s : sda_s};

  // Next-state logic for both link modes
  always_comb begin
    s_d = s_q;
    s_d.scl_p = scl_s;
    s_d.sda_p = sda_s;
    s_d.sel_p = sel_s;
    s_d.wr_stb = 1'b0;
    s_d.strap = strap_s;
    if (sel_fall) begin
      s_d.spi = 1'b1;
      s_d.st = DS_ADDR;
      s_d.cnt = 4'h0;
    end
    if (!s_q.spi) begin
      if (i2c_start) begin
        s_d.st = DS_ADDR;
        s_d.cnt = 4'h0;
        s_d.sda_oe = 1'b0;
      end else if (i2c_stop) begin
        s_d.st = DS_IDLE;
        s_d.sda_oe = 1'b0;
      end else if (rise) begin
        case (s_q.st)
          DS_ADDR, DS_PTR, DS_WDATA: begin
            s_d.sh = byte_in;
            s_d.cnt = s_q.cnt + 4'h1;
          end
          DS_ACKR: begin
            // Host NACK ends the stream; an ACK reloads on the fall
            s_d.st = sda_s ? DS_IGNORE : DS_ACKR;
          end
          default: begin
          end
        endcase
      end else if (fall) begin
        case (s_q.st)
          DS_ADDR: begin
            if (s_q.cnt == 4'h8) begin
              if (s_q.sh[7:3] == `DMCP_I2C_ADDR_HI && s_q.sh[2] == s_q.strap && s_q.sh[1] == sel_s) begin
                s_d.rw = s_q.sh[0];
                s_d.st = DS_ACKA;
                s_d.sda_oe = 1'b1;
              end else begin
                s_d.st = DS_IGNORE;
              end
            end
          end
          DS_ACKA: begin
            s_d.cnt = 4'h0;
            if (s_q.rw) begin
              s_d.st = DS_RDATA;
              s_d.sh = rd_reg(s_q.regs, s_q.ptr[3:0]);
              s_d.sda_oe = ~s_d.sh[7];
            end else begin
              s_d.st = DS_PTR;
              s_d.sda_oe = 1'b0;
            end
          end
          DS_PTR, DS_WDATA: begin
            if (s_q.cnt == 4'h8) begin
              s_d.st = DS_ACKW;
              s_d.sda_oe = 1'b1;
              if (s_q.st == DS_PTR) begin
                s_d.ptr = s_q.sh;
              end else begin
                if (s_q.ptr[3:0] != `DMCP_ID_INDEX) begin
                  s_d.regs[s_q.ptr[3:0]] = s_q.sh;
                end
                s_d.wr_stb = 1'b1;
                s_d.wr_idx = s_q.ptr[3:0];
                s_d.wr_dat = s_q.sh;
                s_d.ptr[3:0] = next_idx(s_q.ptr);
              end
            end
          end
          DS_ACKW: begin
            s_d.st = DS_WDATA;
            s_d.cnt = 4'h0;
            s_d.sda_oe = 1'b0;
          end
          DS_RDATA: begin
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt == 4'h7) begin
              s_d.st = DS_ACKR;
              s_d.sda_oe = 1'b0;
              s_d.ptr[3:0] = next_idx(s_q.ptr);
            end else begin
              s_d.sh = {s_q.sh[6:0], 1'b0};
              s_d.sda_oe = ~s_q.sh[6];
            end
          end
          DS_ACKR: begin
            s_d.st = DS_RDATA;
            s_d.cnt = 4'h0;
            s_d.sh = rd_reg(s_q.regs, s_q.ptr[3:0]);
            s_d.sda_oe = ~s_d.sh[7];
          end
          default: begin
          end
        endcase
      end
    end else begin
      // SPI: select frames, rising clock samples
      s_d.sda_oe = 1'b0;
      if (sel_s) begin
        s_d.st = DS_ADDR;
        s_d.cnt = 4'h0;
      end else if (sel_fall || sel_rise) begin
        s_d.st = DS_ADDR;
        s_d.cnt = 4'h0;
      end else if (rise) begin
        s_d.sh = byte_in;
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == 4'h7) begin
          s_d.cnt = 4'h0;
          case (s_q.st)
            DS_ADDR: begin
              if (byte_in == `DMCP_SPI_ADDR_WR) begin
                s_d.st = DS_PTR;
              end else if (byte_in == `DMCP_SPI_ADDR_RD) begin
                s_d.st = DS_RDATA;
                s_d.sh = rd_reg(s_q.regs, s_q.ptr[3:0]);
              end else begin
                s_d.st = DS_IGNORE;
              end
            end
            DS_PTR: begin
              s_d.ptr = byte_in;
              s_d.st = DS_WDATA;
            end
            DS_WDATA: begin
              if (s_q.ptr[3:0] != `DMCP_ID_INDEX) begin
                s_d.regs[s_q.ptr[3:0]] = byte_in;
              end
              s_d.wr_stb = 1'b1;
              s_d.wr_idx = s_q.ptr[3:0];
              s_d.wr_dat = byte_in;
              s_d.ptr[3:0] = next_idx(s_q.ptr);
            end
            DS_RDATA: begin
              s_d.ptr[3:0] = next_idx(s_q.ptr);
              s_d.sh = rd_reg(s_q.regs, next_idx(s_q.ptr));
            end
            default: begin
            end
          endcase
        end else if (s_q.st == DS_RDATA) begin
          s_d.sh = {s_q.sh[6:0], 1'b0};
        end
      end
      s_d.sdo = s_d.sh[7];
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= DS_IDLE;
      s_q.ptr <= `DMCP_PTR_RESET;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.sel_p <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.sda_dev_oe = s_q.sda_oe;
  assign port.sdo = s_q.sdo;
  assign port.sdo_oe = s_q.spi & ~sel_s & (s_q.st == DS_RDATA);
  assign spi_mode_o = s_q.spi;
  assign pointer_o = s_q.ptr;
  assign wr_stb_o = s_q.wr_stb;
  assign wr_index_o = s_q.wr_idx;
  assign wr_data_o = s_q.wr_dat;
endmodule : dmcp_device

// >>> dmcp_host.sv
`timescale 1ns/1ps
`include "dmcp_regs.svh"
module dmcp_host
  import dmcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  dmcp_if.host port,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o
);
  // CTRL: [0] go, [1] stop after byte, [2] start before byte, [3] read byte, [4] spi, [5] ack on read
  typedef struct packed {
    dmcp_hstate_t st;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [5:0] ctl;
    logic nack;
    logic scl;
    logic sda_oe;
    logic sel;
    logic sdi;
    logic ack;
    logic [31:0] rdat;
  } dmcp_host_t;

  dmcp_host_t h_q;
  dmcp_host_t h_d;
  logic [1:0] sy;
  logic sda_s;
  logic sdo_s;
  logic tick;
  logic wr;

  dmcp_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({port.sda, port.sdo}),
    .q_o(sy)
  );
  assign {sda_s, sdo_s} = sy;
  assign tick = (h_q.div == `DMCP_HALF_DIV);
  // Write lands at the edge where the master sees ack high
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & h_q.ack & wb_sel_i[0];

  // Bit engine: four ticks per bit, MSB first
  always_comb begin
    h_d = h_q;
    h_d.ack = wb_cyc_i & wb_stb_i & ~h_q.ack;
    h_d.div = tick ? 8'd0 : h_q.div + 8'd1;
    // Read data latched at the edge that takes the request
    if (wb_cyc_i && wb_stb_i && !h_q.ack) begin
      case (wb_adr_i)
        `DMCP_H_DATA: h_d.rdat = {24'h0, h_q.rx};
        `DMCP_H_STAT: h_d.rdat = {30'h0, h_q.nack, h_q.st != HS_IDLE};
        `DMCP_H_CTRL: h_d.rdat = {26'h0, h_q.ctl};
        default: h_d.rdat = 32'h0;
      endcase
    end
    if (wr && wb_adr_i == `DMCP_H_DATA) begin
      h_d.tx = wb_dat_i[7:0];
    end
    if (wr && wb_adr_i == `DMCP_H_CTRL && h_q.st == HS_IDLE) begin
      h_d.ctl = wb_dat_i[5:0];
      if (wb_dat_i[0]) begin
        h_d.st = wb_dat_i[2] ? HS_START : HS_BIT;
        h_d.bitn = 4'h0;
        h_d.ph = 2'd0;
      end
    end else if (tick) begin
      h_d.ph = h_q.ph + 2'd1;
      case (h_q.st)
        HS_START: begin
          if (h_q.ctl[4]) begin
            h_d.sel = (h_q.ph != 2'd0);
            if (h_q.ph == 2'd3) h_d.st = HS_BIT;
          end else begin
            case (h_q.ph)
              2'd0: begin h_d.sda_oe = 1'b0; h_d.scl = 1'b0; end
              2'd1: h_d.scl = 1'b1;
              2'd2: h_d.sda_oe = 1'b1;
              default: begin h_d.scl = 1'b0; h_d.st = HS_BIT; end
            endcase
          end
          if (h_q.ph == 2'd3 && h_q.ctl[4]) h_d.sel = 1'b0;
        end
        HS_BIT, HS_ACK: begin
          case (h_q.ph)
            2'd0: begin
              h_d.scl = 1'b0;
              if (h_q.st == HS_ACK) h_d.sda_oe = h_q.ctl[3] & h_q.ctl[5];
              else if (h_q.ctl[3] && !h_q.ctl[4]) h_d.sda_oe = 1'b0;
              else begin h_d.sda_oe = ~h_q.tx[7] & ~h_q.ctl[4]; h_d.sdi = h_q.tx[7]; end
            end
            2'd1: h_d.scl = 1'b1;
            2'd2: begin
              if (h_q.st == HS_ACK) h_d.nack = sda_s;
              else h_d.rx = {h_q.rx[6:0], h_q.ctl[4] ? sdo_s : sda_s};
            end
            default: begin
              h_d.scl = h_q.ctl[4];
              if (h_q.st == HS_ACK || (h_q.ctl[4] && h_q.bitn == 4'h7)) begin
                h_d.st = h_q.ctl[1] ? HS_STOP : HS_DONE;
              end else if (h_q.bitn == 4'h7) begin
                h_d.st = HS_ACK;
              end else begin
                h_d.bitn = h_q.bitn + 4'h1;
                h_d.tx = {h_q.tx[6:0], 1'b0};
              end
              if (h_q.ctl[4]) h_d.scl = 1'b0;
            end
          endcase
        end
        HS_STOP: begin
          case (h_q.ph)
            2'd0: begin h_d.scl = 1'b0; h_d.sda_oe = ~h_q.ctl[4]; end
            2'd1: h_d.scl = ~h_q.ctl[4]; // No stray clock edge while still selected
            2'd2: begin h_d.sda_oe = 1'b0; h_d.sel = 1'b1; end
            default: h_d.st = HS_DONE;
          endcase
        end
        HS_DONE: h_d.st = HS_IDLE;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_q <= '0;
      h_q.st <= HS_IDLE;
      h_q.scl <= 1'b1;
      h_q.sel <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign wb_dat_o = h_q.rdat;
  assign wb_ack_o = h_q.ack;
  assign port.scl = h_q.scl;
  assign port.sda_host_oe = h_q.sda_oe;
  assign port.sel = h_q.sel;
  assign port.sdi = h_q.sdi;
endmodule : dmcp_host

// >>> dmcp_if.sv
`timescale 1ns/1ps
interface dmcp_if;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic sel;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sda;
  // Open drain: low when either end pulls
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport dev (input scl, input sda, input sel, input sdi, output sda_dev_oe, output sdo, output sdo_oe);
  modport host (output scl, input sda, output sel, output sdi, output sda_host_oe, input sdo, input sdo_oe);
endinterface : dmcp_if

// >>> dmcp_pkg.sv
package dmcp_pkg;
  typedef enum {DS_IDLE, DS_ADDR, DS_ACKA, DS_PTR, DS_ACKW, DS_WDATA, DS_RDATA, DS_ACKR, DS_IGNORE} dmcp_dstate_t;
  typedef enum {HS_IDLE, HS_START, HS_BIT, HS_ACK, HS_STOP, HS_DONE} dmcp_hstate_t;
endpackage : dmcp_pkg

// >>> dmcp_regs.svh
`ifndef DMCP_REGS_SVH
`define DMCP_REGS_SVH
// Address byte layout
`define DMCP_I2C_ADDR_HI 5'b10010
`define DMCP_SPI_ADDR_WR 8'h9e
`define DMCP_SPI_ADDR_RD 8'h9f
// Pointer byte fields
`define DMCP_PTR_AUTO_INCREMENT_ENABLE_BIT 7
`define DMCP_PTR_IDX_MSB 3
`define DMCP_PTR_RESET 8'h00
// Read-only identification register index
`define DMCP_ID_INDEX 4'h1
// Host controller register offsets (byte addresses)
`define DMCP_H_CTRL 4'h0
`define DMCP_H_ADDR 4'h4
`define DMCP_H_DATA 4'h8
`define DMCP_H_STAT 4'hc
// Tick divider terminal count: one tick every 5 system clocks, two ticks per link clock half period
`define DMCP_HALF_DIV 8'd4
`endif

// >>> dmcp_sync.sv
`timescale 1ns/1ps
module dmcp_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // Two-stage synchroniser, resets to idle-high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule : dmcp_sync

// >>> dual_mode_control_port_test.sv
`timescale 1ns/1ps
`include "dmcp_regs.svh"
module dual_mode_control_port_test;
  import dmcp_pkg::*;
  localparam logic [7:0] ID_V = 8'h6c; // Arbitrary identification value
  localparam logic [7:0] GO = 8'h01, STP = 8'h02, STA = 8'h04, RD = 8'h08, SPI = 8'h10, RACK = 8'h20;
  logic clk_i, rst_i, strap, wb_we, wb_cyc, wb_stb, wb_ack, spi_mode, wr_stb, nk;
  logic [3:0] wb_adr, wr_idx, wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [7:0] ptr, wr_dat, rx;
  logic [11:0] wq[$];
  int n_fail, total_checks;
  dmcp_if link ();
  dmcp_device #(.ID_VALUE(ID_V)) u_dmcp_device (.clk_i(clk_i), .rst_i(rst_i), .port(link),
    .addr1_strap_pin_i(strap), .spi_mode_o(spi_mode), .pointer_o(ptr), .wr_stb_o(wr_stb),
    .wr_index_o(wr_idx), .wr_data_o(wr_dat));
  dmcp_host u_dmcp_host (.clk_i(clk_i), .rst_i(rst_i), .port(link), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack));
  dmcp_checker u_dmcp_checker (.clk_i(clk_i), .rst_i(rst_i), .scl(link.scl), .sda(link.sda),
    .sda_dev_oe(link.sda_dev_oe), .sel(link.sel), .sdo_oe(link.sdo_oe));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Collect register writes seen by the device
  always @(posedge clk_i) begin
    if (wr_stb === 1'b1) wq.push_back({wr_idx, wr_dat});
  end
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic Wishbone cycle, entered just after a rising edge
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    wb_adr <= a;
    wb_we <= w;
    wb_wdat <= d;
    wb_sel <= 4'h1;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge clk_i);
  endtask : wb
  // One byte on the link through the host controller
  task automatic xfer(input logic [7:0] ctl, input logic [7:0] tx);
    logic [31:0] r;
    wb(`DMCP_H_DATA, 1'b1, {24'h0, tx}, r);
    wb(`DMCP_H_CTRL, 1'b1, {24'h0, ctl}, r);
    r = 32'h1;
    while (r[0] !== 1'b0) wb(`DMCP_H_STAT, 1'b0, 32'h0, r);
    nk = r[1];
    wb(`DMCP_H_DATA, 1'b0, 32'h0, r);
    rx = r[7:0];
  endtask : xfer
  task automatic wr_chk(input logic [11:0] e);
    logic [11:0] v;
    v = 'x;
    if (wq.size() != 0) v = wq.pop_front();
    check("register write", {20'h0, v}, {20'h0, e});
  endtask : wr_chk
  // Watchdog
  initial begin
    #3000000;
    n_fail++;
    complete_run();
  end
  initial begin
    n_fail = 0;
    total_checks = 0;
    rst_i = 1'b1;
    strap = 1'b1;
    {wb_we, wb_cyc, wb_stb} = 3'b000;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("pointer", ptr, 8'h00);
    check("mode", spi_mode, 1'b0);
    // Foreign addresses: wrong strap bit, wrong upper bits
    xfer(GO | STA | STP, 8'h92);
    check("nack strap", nk, 1'b1);
    xfer(GO | STA | STP, 8'hd6);
    check("nack upper", nk, 1'b1);
    check("no write", wq.size(), 0);
    // Auto-increment write of two registers
    xfer(GO | STA, 8'h96);
    check("ack addr", nk, 1'b0);
    xfer(GO, 8'h85);
    xfer(GO, 8'h5a);
    xfer(GO | STP, 8'ha5);
    wr_chk({4'h5, 8'h5a});
    wr_chk({4'h6, 8'ha5});
    check("pointer step", ptr, 8'h87);
    // Write attempt on the identification register, then read it back twice
    xfer(GO | STA, 8'h96);
    xfer(GO, 8'h01);
    xfer(GO | STP, 8'h00);
    wq.delete();
    xfer(GO | STA, 8'h96);
    xfer(GO, 8'h01);
    xfer(GO | STA, 8'h97);
    xfer(GO | RD | RACK, 8'hff);
    check("id read", rx, ID_V);
    xfer(GO | RD | STP, 8'hff);
    check("id again", rx, ID_V);
    check("pointer held", ptr, 8'h01);
    // Auto-increment read streams two registers under host acknowledge
    xfer(GO | STA, 8'h96);
    xfer(GO, 8'h85);
    xfer(GO | STA, 8'h97);
    xfer(GO | RD | RACK, 8'hff);
    check("auto_increment_enable read", rx, 8'h5a);
    xfer(GO | RD | STP, 8'hff);
    check("auto_increment_enable next", rx, 8'ha5);
    check("pointer read step", ptr, 8'h87);
    // Four-wire write of two registers under one select
    xfer(GO | SPI | STA, `DMCP_SPI_ADDR_WR);
    check("mode spi", spi_mode, 1'b1);
    xfer(GO | SPI, 8'h83);
    xfer(GO | SPI, 8'h11);
    xfer(GO | SPI | STP, 8'h22);
    wr_chk({4'h3, 8'h11});
    wr_chk({4'h4, 8'h22});
    check("spi pointer", ptr, 8'h85);
    // Four-wire pointer set then read
    xfer(GO | SPI | STA, `DMCP_SPI_ADDR_WR);
    xfer(GO | SPI | STP, 8'h01);
    xfer(GO | SPI | STA, `DMCP_SPI_ADDR_RD);
    xfer(GO | SPI | RD | STP, 8'h00);
    check("spi id", rx, ID_V);
    // Unmapped host address still answers
    wb(`DMCP_H_ADDR, 1'b0, 32'h0, q);
    check("mode kept", spi_mode, 1'b1);
    complete_run();
  end
endmodule : dual_mode_control_port_test
